// ==== src/nvc_defs.svh ====
// Constants for the host-side controller of a shadowed static memory.
// Assumes a 250 MHz mclk; pin timing counts are whole mclk cycles.
`ifndef NVC_DEFS_SVH
`define NVC_DEFS_SVH
`define NVC_CLK_MHZ 250
`define NVC_ACCESS_NS 45
`define NVC_ACCESS_CYC ((`NVC_ACCESS_NS * `NVC_CLK_MHZ + 999) / 1000)
`define NVC_COPY_OUT_TIME_US 10000
`define NVC_COPY_IN_TIME_US 20
`define NVC_POWER_UP_COPY_TIME_US 550
`define NVC_COPY_OUT_CYC (`NVC_COPY_OUT_TIME_US * `NVC_CLK_MHZ)
`define NVC_COPY_IN_CYC (`NVC_COPY_IN_TIME_US * `NVC_CLK_MHZ)
`define NVC_POWER_UP_COPY_CYC (`NVC_POWER_UP_COPY_TIME_US * `NVC_CLK_MHZ)
`define NVC_SEQ_A0 14'h0E38
`define NVC_SEQ_A1 14'h31C7
`define NVC_SEQ_A2 14'h03E0
`define NVC_SEQ_A3 14'h3C1F
`define NVC_SEQ_A4 14'h303F
`define NVC_SEQ_STORE 14'h0FC0
`define NVC_SEQ_RECALL 14'h0C63
`endif

// ==== src/nvc_host.sv ====
// Host controller driving a shadowed static memory over its parallel pins.
// Assumes the memory sits off chip; its data pins return asynchronously.
`timescale 1ns/1ps
`include "nvc_defs.svh"
module nvc_host import nvc_pkg::*; #(
    parameter int ACCESS_CYC = `NVC_ACCESS_CYC,
    parameter int COPY_OUT_CYC = `NVC_COPY_OUT_CYC,
    parameter int COPY_IN_CYC = `NVC_COPY_IN_CYC,
    parameter int POWER_UP_COPY_CYC = `NVC_POWER_UP_COPY_CYC
) (
    // Clock and reset
    input wire logic mclk,
    input wire logic resetn,
    // User command port
    input wire logic req_valid,
    input wire logic [1:0] req_cmd,
    input wire logic [14:0] req_addr,
    input wire logic [7:0] req_wdata,
    output logic req_ready,
    output logic rsp_valid,
    output logic [7:0] rsp_rdata,
    // Supply monitor level, asynchronous
    input wire logic supply_ok,
    // Memory pins
    output logic cs_n,
    output logic out_drv_n,
    output logic data_latch_n,
    output logic [14:0] mem_addr,
    input wire logic [7:0] dq_in,
    output logic [7:0] dq_out,
    output logic dq_oe_n
);
    logic rst_s1, rst_n;
    logic [7:0] dq_s1, dq_s2;
    logic sup_s1, sup_s2, sup_prev;
    nvc_state_t state;
    nvc_cmd_t cmd;
    logic [2:0] step;
    logic [7:0] tmr;
    logic start_wait;
    logic [23:0] wait_cycles;
    logic busy;
    logic seq_write;
    logic [14:0] seq_addr;

    // Reset release through two flops
    always_ff @(posedge mclk or negedge resetn) begin
        if (!resetn) begin
            rst_s1 <= 1'b0;
            rst_n <= 1'b0;
        end else begin
            rst_s1 <= 1'b1;
            rst_n <= rst_s1;
        end
    end

    // Pin inputs are asynchronous to mclk
    always_ff @(posedge mclk or negedge rst_n) begin
        if (!rst_n) begin
            dq_s1 <= 8'h00;
            dq_s2 <= 8'h00;
            sup_s1 <= 1'b0;
            sup_s2 <= 1'b0;
            sup_prev <= 1'b0;
        end else begin
            dq_s1 <= dq_in;
            dq_s2 <= dq_s1;
            sup_s1 <= supply_ok;
            sup_s2 <= sup_s1;
            sup_prev <= sup_s2;
        end
    end

    function automatic logic [14:0] seq_at(input logic [2:0] i, input nvc_cmd_t c);
        unique case (i)
            3'h0: seq_at = {1'b0, `NVC_SEQ_A0};
            3'h1: seq_at = {1'b0, `NVC_SEQ_A1};
            3'h2: seq_at = {1'b0, `NVC_SEQ_A2};
            3'h3: seq_at = {1'b0, `NVC_SEQ_A3};
            3'h4: seq_at = {1'b0, `NVC_SEQ_A4};
            default: seq_at = {1'b0, (c == NVC_CMD_STORE) ? `NVC_SEQ_STORE : `NVC_SEQ_RECALL};
        endcase
    endfunction : seq_at

    nvc_wait #(.WIDTH(24)) u_wait (
        .mclk(mclk),
        .rst_n(rst_n),
        .start(start_wait),
        .cycles(wait_cycles),
        .busy(busy)
    );

    // Supply rise starts a power-up recall; device refuses access meanwhile
    always_comb begin
        start_wait = 1'b0;
        wait_cycles = 24'h000000;
        if (sup_s2 && !sup_prev) begin
            start_wait = 1'b1;
            wait_cycles = 24'(POWER_UP_COPY_CYC);
        end else if (state == NVC_GAP && tmr == 8'h00 && step == 3'h5
                     && (cmd == NVC_CMD_STORE || cmd == NVC_CMD_RECALL)) begin
            start_wait = 1'b1;
            wait_cycles = (cmd == NVC_CMD_STORE) ? 24'(COPY_OUT_CYC) : 24'(COPY_IN_CYC);
        end
    end

    assign seq_write = (cmd == NVC_CMD_WRITE);
    assign seq_addr = seq_at(step, cmd);

    // Access sequencer: one select pulse per step, no double edges
    always_ff @(posedge mclk or negedge rst_n) begin
        if (!rst_n) begin
            state <= NVC_IDLE;
            cmd <= NVC_CMD_READ;
            step <= 3'h0;
            tmr <= 8'h00;
            cs_n <= 1'b1;
            out_drv_n <= 1'b1;
            data_latch_n <= 1'b1;
            mem_addr <= 15'h0000;
            dq_out <= 8'h00;
            dq_oe_n <= 1'b1;
            req_ready <= 1'b0;
            rsp_valid <= 1'b0;
            rsp_rdata <= 8'h00;
        end else begin
            rsp_valid <= 1'b0;
            unique case (state)
                NVC_IDLE: begin
                    // A supply rise seen this cycle starts a copy, so ready drops with it
                    req_ready <= !busy && !start_wait && sup_s2;
                    if (req_valid && req_ready) begin
                        req_ready <= 1'b0;
                        cmd <= nvc_cmd_t'(req_cmd);
                        step <= 3'h0;
                        if (nvc_cmd_t'(req_cmd) == NVC_CMD_READ
                            || nvc_cmd_t'(req_cmd) == NVC_CMD_WRITE) begin
                            mem_addr <= req_addr;
                            dq_out <= req_wdata;
                        end else begin
                            mem_addr <= {1'b0, `NVC_SEQ_A0};
                        end
                        tmr <= 8'h01;
                        state <= NVC_SETUP;
                    end
                end
                NVC_SETUP: begin
                    // Address settles before select falls; a copy started after
                    // the take holds select off until the copy is over
                    if (tmr != 8'h00) begin
                        tmr <= tmr - 8'h01;
                    end else if (!busy && !start_wait) begin
                        cs_n <= 1'b0;
                        data_latch_n <= !seq_write;
                        out_drv_n <= !(cmd == NVC_CMD_READ);
                        dq_oe_n <= !seq_write;
                        tmr <= 8'(ACCESS_CYC);
                        state <= NVC_PULSE;
                    end
                end
                NVC_PULSE: begin
                    tmr <= tmr - 8'h01;
                    if (tmr == 8'h00) begin
                        if (cmd == NVC_CMD_READ) begin
                            rsp_rdata <= dq_s2;
                            rsp_valid <= 1'b1;
                        end
                        // Strobe rise ends the write with data held one more cycle
                        data_latch_n <= 1'b1;
                        cs_n <= 1'b1;
                        out_drv_n <= 1'b1;
                        tmr <= 8'h02;
                        state <= NVC_GAP;
                    end
                end
                NVC_GAP: begin
                    dq_oe_n <= 1'b1;
                    tmr <= tmr - 8'h01;
                    if (tmr == 8'h00) begin
                        if ((cmd == NVC_CMD_STORE || cmd == NVC_CMD_RECALL) && step != 3'h5) begin
                            step <= step + 3'h1;
                            mem_addr <= seq_at(step + 3'h1, cmd);
                            tmr <= 8'h01;
                            state <= NVC_SETUP;
                        end else begin
                            state <= NVC_WAIT;
                        end
                    end
                end
                NVC_WAIT: begin
                    // Device is busy after a copy; bus stays floated
                    if (!busy && !start_wait) begin
                        state <= NVC_IDLE;
                    end
                end
                default: state <= NVC_IDLE;
            endcase
        end
    end

    property p_seq_addr;
        @(posedge mclk) disable iff (!rst_n)
        $fell(cs_n) && (cmd == NVC_CMD_STORE || cmd == NVC_CMD_RECALL) |-> mem_addr == seq_addr;
    endproperty
    a_seq_addr: assert property (p_seq_addr) else $error("sequence address out of order");

    property p_seq_no_write;
        @(posedge mclk) disable iff (!rst_n)
        (cmd == NVC_CMD_STORE || cmd == NVC_CMD_RECALL) && !cs_n |-> data_latch_n;
    endproperty
    a_seq_no_write: assert property (p_seq_no_write) else $error("strobe low in sequence");

    property p_write_drv;
        @(posedge mclk) disable iff (!rst_n)
        !data_latch_n |-> out_drv_n && !dq_oe_n && !cs_n;
    endproperty
    a_write_drv: assert property (p_write_drv) else $error("drive low during write");

    sequence s_write_end;
        !data_latch_n ##1 data_latch_n;
    endsequence
    property p_addr_hold;
        @(posedge mclk) disable iff (!rst_n)
        s_write_end |-> $stable(mem_addr) && !dq_oe_n;
    endproperty
    a_addr_hold: assert property (p_addr_hold) else $error("address moved at write end");

    property p_busy_idle;
        @(posedge mclk) disable iff (!rst_n)
        busy |-> cs_n;
    endproperty
    a_busy_idle: assert property (p_busy_idle) else $error("access during copy");

    property p_drv_no_clash;
        @(posedge mclk) disable iff (!rst_n)
        !out_drv_n |-> data_latch_n && dq_oe_n;
    endproperty
    a_drv_no_clash: assert property (p_drv_no_clash) else $error("bus clash on read");
endmodule : nvc_host

// ==== src/nvc_pkg.sv ====
// Types for the shadowed memory host controller.
// Constants live in nvc_defs.svh.
package nvc_pkg;
    typedef enum logic [1:0] {
        NVC_CMD_READ = 2'h0,
        NVC_CMD_WRITE = 2'h1,
        NVC_CMD_STORE = 2'h2,
        NVC_CMD_RECALL = 2'h3
    } nvc_cmd_t;
    typedef enum logic [2:0] {
        NVC_IDLE = 3'h0,
        NVC_SETUP = 3'h1,
        NVC_PULSE = 3'h2,
        NVC_GAP = 3'h3,
        NVC_WAIT = 3'h4
    } nvc_state_t;
endpackage : nvc_pkg

// ==== src/nvc_wait.sv ====
// Busy timer: holds busy for a loaded number of cycles.
// Assumes start pulses come from the same clock domain.
`timescale 1ns/1ps
module nvc_wait #(
    parameter int WIDTH = 22
) (
    // Clock and reset
    input wire logic mclk,
    input wire logic rst_n,
    // Control
    input wire logic start,
    input wire logic [WIDTH-1:0] cycles,
    output logic busy
);
    logic [WIDTH-1:0] count;

    always_ff @(posedge mclk or negedge rst_n) begin
        if (!rst_n) begin
            count <= '0;
        end else if (start) begin
            count <= cycles;
        end else if (count != '0) begin
            count <= count - WIDTH'(1);
        end
    end

    assign busy = (count != '0);
endmodule : nvc_wait

// ==== tb/nvc_mem_model.sv ====
// Behavioural shadowed static memory on the far side of the host controller.
// Assumes the bench resolves the shared data lines and feeds them back on dq.
`timescale 1ns/1ps
`include "nvc_defs.svh"
module nvc_mem_model #(
    parameter int BUSY_NS = 200,
    parameter int UP_NS = 60
) (
    // Memory pins
    input wire logic cs_n,
    input wire logic out_drv_n,
    input wire logic data_latch_n,
    input wire logic [14:0] mem_addr,
    input wire logic [7:0] dq,
    input wire logic supply_ok,
    output logic [7:0] dq_drv,
    output logic dq_en
);
    logic [7:0] mem [0:32767];
    logic [7:0] shadow [0:32767];
    logic [7:0] last = 8'h00;
    logic busy = 1'b0;
    logic dirty = 1'b0;
    logic wr;
    int step = 0;
    function automatic logic [13:0] seq(input int i);
        case (i)
            0: return `NVC_SEQ_A0;
            1: return `NVC_SEQ_A1;
            2: return `NVC_SEQ_A2;
            3: return `NVC_SEQ_A3;
            default: return `NVC_SEQ_A4;
        endcase
    endfunction : seq
    task automatic run(input logic st);
        busy = 1'b1;
        step = 0;
        dirty = 1'b0;
        // Erase is implicit: every cell is overwritten in one pass
        for (int i = 0; i < 32768; i++) begin
            if (st) shadow[i] = mem[i];
            else mem[i] = shadow[i];
        end
        #(BUSY_NS);
        busy = 1'b0;
    endtask : run
    assign wr = !cs_n && !data_latch_n;
    assign dq_en = !cs_n && !out_drv_n && data_latch_n && !busy;
    // No pull-up on the bus, so a released bus shows the inverse of the last byte
    assign dq_drv = dq_en ? mem[mem_addr] : last;
    always @(negedge dq_en) last = ~mem[mem_addr];
    always @(negedge wr) begin
        if (!busy && supply_ok === 1'b1) begin
            mem[mem_addr] = dq;
            dirty = 1'b1;
        end
    end
    // Supply loss copies out only if written since the last copy
    always @(negedge supply_ok) begin
        if (dirty) begin
            for (int i = 0; i < 32768; i++) shadow[i] = mem[i];
            dirty = 1'b0;
        end
    end
    // Supply return copies in once and refuses access meanwhile
    always @(posedge supply_ok) begin
        busy = 1'b1;
        step = 0;
        for (int i = 0; i < 32768; i++) mem[i] = shadow[i];
        dirty = 1'b0;
        #(UP_NS);
        busy = 1'b0;
    end
    always @(negedge cs_n) begin
        #1;
        if (!data_latch_n || busy) step = 0;
        else if (step == 5 && mem_addr[13:0] == `NVC_SEQ_STORE && supply_ok) run(1'b1);
        else if (step == 5 && mem_addr[13:0] == `NVC_SEQ_RECALL) run(1'b0);
        else if (step < 5 && mem_addr[13:0] == seq(step)) step++;
        else step = int'(mem_addr[13:0] == `NVC_SEQ_A0);
    end
endmodule : nvc_mem_model

// ==== tb/tb_nvc_host.sv ====
// Self-checking bench for the shadowed memory host controller.
// Assumes nvc_mem_model on the pins; contention on dq resolves to unknown.
`timescale 1ns/1ps
module tb_nvc_host;
    import nvc_pkg::*;
    localparam int COPY_CYC = 80;
    localparam int UP_CYC = 20;
    logic mclk = 1'b0;
    logic resetn = 1'b0;
    logic req_valid = 1'b0;
    logic [1:0] req_cmd = 2'h0;
    logic [14:0] req_addr = 15'h0000;
    logic [7:0] req_wdata = 8'h00;
    logic supply_ok = 1'b1;
    logic req_ready, rsp_valid, cs_n, out_drv_n, data_latch_n, dq_oe_n, dq_en;
    logic [7:0] rsp_rdata, dq_out, dq_drv;
    wire [7:0] dq;
    logic [14:0] mem_addr;
    int fails = 0;
    int cmp_count = 0;
    int cnt;
    assign dq = !dq_oe_n ? (dq_en ? 8'hXX : dq_out) : dq_drv;
    always #2 mclk = ~mclk;
    nvc_host #(.COPY_OUT_CYC(COPY_CYC), .COPY_IN_CYC(COPY_CYC), .POWER_UP_COPY_CYC(UP_CYC)) dut_u (
        .mclk(mclk), .resetn(resetn), .req_valid(req_valid), .req_cmd(req_cmd),
        .req_addr(req_addr), .req_wdata(req_wdata), .req_ready(req_ready),
        .rsp_valid(rsp_valid), .rsp_rdata(rsp_rdata), .supply_ok(supply_ok), .cs_n(cs_n),
        .out_drv_n(out_drv_n), .data_latch_n(data_latch_n), .mem_addr(mem_addr),
        .dq_in(dq), .dq_out(dq_out), .dq_oe_n(dq_oe_n));
    nvc_mem_model #(.BUSY_NS(200), .UP_NS(60)) mem_u (
        .cs_n(cs_n), .out_drv_n(out_drv_n), .data_latch_n(data_latch_n),
        .mem_addr(mem_addr), .dq(dq), .supply_ok(supply_ok), .dq_drv(dq_drv), .dq_en(dq_en));
    task automatic chk(input string what, input logic [7:0] exp, input logic [7:0] got);
        cmp_count++;
        if (got !== exp) begin
            fails++;
            $display("CHECK FAILED %s expected %h seen %h", what, exp, got);
        end
    endtask : chk
    task automatic issue(input nvc_cmd_t cmd, input logic [14:0] addr, input logic [7:0] wd);
        @(negedge mclk);
        req_valid = 1'b1;
        req_cmd = cmd;
        req_addr = addr;
        req_wdata = wd;
        // Ready seen settled here stands until the edge that takes the request
        while (req_ready !== 1'b1) @(negedge mclk);
        @(negedge mclk);
        req_valid = 1'b0;
    endtask : issue
    task automatic rd(input logic [14:0] addr, input logic [7:0] exp);
        issue(NVC_CMD_READ, addr, 8'h00);
        while (rsp_valid !== 1'b1) @(negedge mclk);
        chk("read data", exp, rsp_rdata);
    endtask : rd
    task automatic t_rw();
        logic [14:0] a [4] = '{15'h0000, 15'h7FFF, 15'h3FFF, 15'h1234};
        for (int i = 0; i < 4; i++) issue(NVC_CMD_WRITE, a[i], 8'(8'h11 * (i + 1)));
        for (int i = 0; i < 4; i++) rd(a[i], 8'(8'h11 * (i + 1)));
    endtask : t_rw
    task automatic t_copy();
        issue(NVC_CMD_WRITE, 15'h0100, 8'hA5);
        issue(NVC_CMD_STORE, 15'h0000, 8'h00);
        // Count only the quiet cycles after the last select pulse
        cnt = 0;
        while (req_ready !== 1'b1) begin
            @(negedge mclk);
            cnt = cs_n ? cnt + 1 : 0;
        end
        chk("store busy span", 8'h01, 8'(cnt >= COPY_CYC));
        issue(NVC_CMD_WRITE, 15'h0100, 8'h5A);
        issue(NVC_CMD_WRITE, 15'h0000, 8'hEE);
        issue(NVC_CMD_RECALL, 15'h0000, 8'h00);
        rd(15'h0100, 8'hA5);
        rd(15'h0000, 8'h11);
        issue(NVC_CMD_WRITE, 15'h0100, 8'h3C);
        issue(NVC_CMD_RECALL, 15'h0000, 8'h00);
        rd(15'h0100, 8'hA5);
    endtask : t_copy
    task automatic t_low();
        issue(NVC_CMD_WRITE, 15'h1234, 8'h77);
        while (req_ready !== 1'b1) @(negedge mclk);
        supply_ok = 1'b0;
        repeat (6) @(negedge mclk);
        chk("ready at low supply", 8'h00, {7'h00, req_ready});
        supply_ok = 1'b1;
        cnt = 0;
        while (req_ready !== 1'b1) begin
            @(negedge mclk);
            cnt++;
        end
        chk("power-up hold span", 8'h01, 8'(cnt >= UP_CYC));
        rd(15'h1234, 8'h77);
        rd(15'h7FFF, 8'h22);
    endtask : t_low
    task automatic conclude();
        $display("comparisons %0d mismatches %0d", cmp_count, fails);
        if (fails == 0 && cmp_count > 0) $display("TEST PASSED");
        else $display("TEST FAILED");
        $finish;
    endtask : conclude
    initial begin
        #100000;
        fails++;
        conclude();
    end
    initial begin
        repeat (5) @(posedge mclk);
        @(negedge mclk);
        resetn = 1'b1;
        t_rw();
        t_copy();
        t_low();
        conclude();
    end
endmodule : tb_nvc_host
